// *** common/pvc_pkg.sv ***
package pvc_pkg;

    // register indices on the management interface
    localparam logic [4:0]  REG_CFG_ADDR     = 5'h10;
    localparam logic [4:0]  REG_STAT_ADDR    = 5'h11;

    // configuration register field positions
    localparam int          CFG_RMII_BIT     = 8;
    localparam int          CFG_FLINK_BIT    = 7;
    localparam int          CFG_SPLED_BIT    = 6;
    localparam int          CFG_COLLED_BIT   = 5;
    localparam int          CFG_RPD_BIT      = 4;
    localparam int          CFG_STATE_MACHINE_RESET_BIT    = 3;
    localparam int          CFG_MFPS_BIT     = 2;
    localparam int          CFG_SLEEP_BIT    = 1;
    localparam int          CFG_REMOTE_LOOPOUT_BIT    = 0;
    localparam int          CFG_WIDTH        = 9;

    // status register field positions
    localparam int          STAT_RES_LSB     = 12;
    localparam int          RES_FAST_FDX_BIT = 3;
    localparam int          RES_FAST_HDX_BIT = 2;
    localparam int          RES_SLOW_FDX_BIT = 1;
    localparam int          RES_SLOW_HDX_BIT = 0;

    // values after reset
    localparam logic [8:0]  CFG_RESET        = 9'h010;
    localparam logic [3:0]  RESULT_RESET     = 4'hf;

    // management frame layout
    localparam logic [5:0]  PREAMBLE_BITS    = 6'h20;
    localparam logic [5:0]  HDR_LAST         = 6'h0b;
    localparam logic [5:0]  DATA_LAST        = 6'h0f;
    localparam logic [5:0]  DATA_BITS        = 6'h10;
    localparam logic [1:0]  OP_READ          = 2'h2;
    localparam logic [1:0]  OP_WRITE         = 2'h1;

    // length of the internal state-machine reset pulse
    localparam int          SM_RESET_CYCLES  = 16;

    typedef enum logic [2:0] {
        PVC_PRE,
        PVC_START,
        PVC_HDR,
        PVC_TA,
        PVC_RD,
        PVC_WR
    } pvc_mgmt_state_t;

endpackage

// *** design/pvc_phy_regs.sv ***
// Behaviour
// - strap pin latched into reduced-MII enable at reset
// - force bit makes 100 Mbps link good
// - speed indicator shows signal detect when the bit is set
// - collision enable adds collision to duplex indicator
// - auto reduced power down enabled, resets to one
// - writing one resets all internal state machines
// - state-machine reset bit self-clears when finished
// - preamble suppression bit, resets to zero
// - sleep bit powers down all but clocking
// - wake keeps configuration, reinitialises state machines
// - remote loopout returns receive data to transmit
// - result bit for 100 full duplex
// - result bit for 100 half duplex
// - result bit for 10 full duplex
// - results written after negotiation, reset to ones
// - result bit for 10 half duplex
module pvc_phy_regs
    import pvc_pkg::*;
#(
    parameter int SM_CYCLES = SM_RESET_CYCLES
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       rmii_strap_i,
    input  wire logic [4:0] phy_addr_i,
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    input  wire logic       link_100_raw_i,
    input  wire logic       signal_detect_i,
    input  wire logic       speed_100_i,
    input  wire logic       full_duplex_i,
    input  wire logic       collision_i,
    input  wire logic       energy_detect_i,
    input  wire logic       an_complete_i,
    input  wire logic       an_speed_100_i,
    input  wire logic       an_full_duplex_i,
    output logic            mdio_o,
    output logic            mdio_oe_n_o,
    output logic            rmii_enable_o,
    output logic            link_100_good_o,
    output logic            speed_indicator_out_o,
    output logic            duplex_collision_indicator_out_o,
    output logic            reduced_powerdown_o,
    output logic            powerdown_o,
    output logic            sm_reset_o,
    output logic            remote_loopout_o
);

    typedef struct packed {
        pvc_mgmt_state_t fsm;
        logic [5:0]      cnt;
        logic [11:0]     hdr;
        logic [15:0]     sh;
        logic            sel;
        logic            rd;
        logic            mdc_q;
        logic [8:0]      cfg;
        logic [3:0]      result;
        logic            sm_start;
        logic            sm_rst;
        logic            mdio;
        logic            mdio_oe_n;
        logic            rmii;
        logic            link_good;
        logic            spd_led;
        logic            dup_led;
        logic            rpd;
        logic            pd;
        logic            loop;
    } pvc_state_t;

    pvc_state_t st;
    pvc_state_t next_st;

    logic        gen_busy;
    logic        gen_done;
    logic        mdc_rise;
    logic [11:0] hdr_full;
    logic [15:0] wdata;
    logic [15:0] rd_word;

    pvc_sm_reset_gen #(
        .CYCLES (SM_CYCLES)
    ) u_sm_reset (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .start_i   (st.sm_start),
        .busy_o    (gen_busy),
        .done_o    (gen_done)
    );

    assign mdc_rise = mdc_i & ~st.mdc_q;
    assign hdr_full = {st.hdr[10:0], mdio_i};
    assign wdata    = {st.sh[14:0], mdio_i};

    // readback of the addressed register, unmapped reads return zero
    always_comb begin
        rd_word = 16'h0000;
        if (st.hdr[4:0] == REG_CFG_ADDR) begin
            rd_word[CFG_WIDTH-1:0] = st.cfg;
        end else if (st.hdr[4:0] == REG_STAT_ADDR) begin
            rd_word[STAT_RES_LSB +: 4] = st.result;
        end
    end

    always_comb begin
        next_st          = st;
        next_st.sm_start = 1'b0;
        next_st.mdc_q    = mdc_i;
        next_st.sm_rst   = gen_busy;

        // clear first so a write of one in the same cycle wins
        if (gen_done) begin
            next_st.cfg[CFG_STATE_MACHINE_RESET_BIT] = 1'b0;
        end

        if (an_complete_i) begin
            next_st.result[RES_FAST_FDX_BIT] = an_speed_100_i & an_full_duplex_i;
            next_st.result[RES_FAST_HDX_BIT] = an_speed_100_i & ~an_full_duplex_i;
            next_st.result[RES_SLOW_FDX_BIT] = ~an_speed_100_i & an_full_duplex_i;
            next_st.result[RES_SLOW_HDX_BIT] = ~an_speed_100_i & ~an_full_duplex_i;
        end

        if (mdc_rise) begin
            unique case (st.fsm)
                PVC_PRE: begin
                    if (mdio_i) begin
                        if (st.cnt != PREAMBLE_BITS) begin
                            next_st.cnt = st.cnt + 6'h01;
                        end
                    end else if (st.cnt == PREAMBLE_BITS || st.cfg[CFG_MFPS_BIT]) begin
                        next_st.fsm = PVC_START;
                        next_st.cnt = 6'h00;
                    end else begin
                        next_st.cnt = 6'h00;
                    end
                end
                PVC_START: begin
                    next_st.cnt = 6'h00;
                    next_st.fsm = mdio_i ? PVC_HDR : PVC_PRE;
                end
                PVC_HDR: begin
                    next_st.hdr = hdr_full;
                    if (st.cnt == HDR_LAST) begin
                        // frames for another address are followed silently
                        next_st.sel = (hdr_full[9:5] == phy_addr_i)
                                      && (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);
                        next_st.rd  = (hdr_full[9:5] == phy_addr_i) && (hdr_full[11:10] == OP_READ);
                        next_st.fsm = PVC_TA;
                        next_st.cnt = 6'h00;
                    end else begin
                        next_st.cnt = st.cnt + 6'h01;
                    end
                end
                PVC_TA: begin
                    if (st.rd) begin
                        // second turnaround bit driven low, data loaded
                        next_st.mdio      = 1'b0;
                        next_st.mdio_oe_n = 1'b0;
                        next_st.sh        = rd_word;
                        next_st.fsm       = PVC_RD;
                        next_st.cnt       = 6'h00;
                    end else if (st.cnt == 6'h01) begin
                        next_st.fsm = PVC_WR;
                        next_st.cnt = 6'h00;
                    end else begin
                        next_st.cnt = st.cnt + 6'h01;
                    end
                end
                PVC_RD: begin
                    if (st.cnt == DATA_BITS) begin
                        next_st.mdio      = 1'b1;
                        next_st.mdio_oe_n = 1'b1;
                        next_st.fsm       = PVC_PRE;
                        next_st.cnt       = 6'h00;
                    end else begin
                        next_st.mdio = st.sh[15];
                        next_st.sh   = {st.sh[14:0], 1'b0};
                        next_st.cnt  = st.cnt + 6'h01;
                    end
                end
                PVC_WR: begin
                    next_st.sh = wdata;
                    if (st.cnt == DATA_LAST) begin
                        // status register is read-only, writes dropped
                        if (st.sel && !st.rd && st.hdr[4:0] == REG_CFG_ADDR) begin
                            next_st.cfg[CFG_WIDTH-1:CFG_STATE_MACHINE_RESET_BIT+1] = wdata[CFG_WIDTH-1:CFG_STATE_MACHINE_RESET_BIT+1];
                            next_st.cfg[CFG_STATE_MACHINE_RESET_BIT-1:0] = wdata[CFG_STATE_MACHINE_RESET_BIT-1:0];
                            // a written zero cannot cut a running reset short
                            next_st.cfg[CFG_STATE_MACHINE_RESET_BIT] = next_st.cfg[CFG_STATE_MACHINE_RESET_BIT] | wdata[CFG_STATE_MACHINE_RESET_BIT];
                            if (wdata[CFG_STATE_MACHINE_RESET_BIT]) begin
                                next_st.sm_start = 1'b1;
                            end
                            // wake keeps every other bit as written or held
                            if (st.cfg[CFG_SLEEP_BIT] && !wdata[CFG_SLEEP_BIT]) begin
                                next_st.sm_start = 1'b1;
                            end
                        end
                        next_st.fsm = PVC_PRE;
                        next_st.cnt = 6'h00;
                    end else begin
                        next_st.cnt = st.cnt + 6'h01;
                    end
                end
            endcase
        end

        // pin-facing outputs; speed and duplex indicators and reduced power down silenced while asleep
        next_st.rmii      = st.cfg[CFG_RMII_BIT];
        next_st.link_good = st.cfg[CFG_FLINK_BIT] | link_100_raw_i;
        next_st.spd_led   = ~st.cfg[CFG_SLEEP_BIT]
                            & (st.cfg[CFG_SPLED_BIT] ? signal_detect_i : speed_100_i);
        next_st.dup_led   = ~st.cfg[CFG_SLEEP_BIT]
                            & (st.cfg[CFG_COLLED_BIT] ? (full_duplex_i | collision_i) : full_duplex_i);
        next_st.rpd       = st.cfg[CFG_RPD_BIT] & ~energy_detect_i & ~st.cfg[CFG_SLEEP_BIT];
        next_st.pd        = st.cfg[CFG_SLEEP_BIT];
        next_st.loop      = st.cfg[CFG_REMOTE_LOOPOUT_BIT];

        if (rst_i) begin
            next_st                    = '0;
            next_st.cfg                = CFG_RESET;
            next_st.cfg[CFG_RMII_BIT]  = rmii_strap_i;
            next_st.result             = RESULT_RESET;
            next_st.mdio               = 1'b1;
            next_st.mdio_oe_n          = 1'b1;
            next_st.mdc_q              = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st <= next_st;
    end

    assign mdio_o                           = st.mdio;
    assign mdio_oe_n_o                      = st.mdio_oe_n;
    assign rmii_enable_o                    = st.rmii;
    assign link_100_good_o                  = st.link_good;
    assign speed_indicator_out_o            = st.spd_led;
    assign duplex_collision_indicator_out_o = st.dup_led;
    assign reduced_powerdown_o              = st.rpd;
    assign powerdown_o                      = st.pd;
    assign sm_reset_o                       = st.sm_rst;
    assign remote_loopout_o                 = st.loop;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_strap_latch: assert property (disable iff (1'b0) rst_i |=> st.cfg[CFG_RMII_BIT] == $past(rmii_strap_i))
        else $error("strap level not latched at reset");
    a_force_link: assert property (st.cfg[CFG_FLINK_BIT] |=> link_100_good_o)
        else $error("forced link not reported good");
    a_speed_led_mux: assert property ((st.cfg[CFG_SPLED_BIT] && !st.cfg[CFG_SLEEP_BIT])
                                      |=> speed_indicator_out_o == $past(signal_detect_i))
        else $error("speed indicator not showing signal detect");
    a_dup_led_mode: assert property ((!st.cfg[CFG_COLLED_BIT] && !st.cfg[CFG_SLEEP_BIT])
                                     |=> duplex_collision_indicator_out_o == $past(full_duplex_i))
        else $error("duplex indicator shows more than duplex");
    a_rpd_reset_one: assert property (disable iff (1'b0) rst_i |=> st.cfg[CFG_RPD_BIT])
        else $error("auto power down enable not one after reset");
    a_rpd_gated: assert property (!st.cfg[CFG_RPD_BIT] |=> !reduced_powerdown_o)
        else $error("reduced power down while disabled");
    a_sm_reset_start: assert property (st.sm_start |-> ##2 sm_reset_o)
        else $error("state machine reset not issued");
    a_sm_bit_clears: assert property ($rose(st.cfg[CFG_STATE_MACHINE_RESET_BIT]) |-> ##[1:40] !st.cfg[CFG_STATE_MACHINE_RESET_BIT])
        else $error("state machine reset bit did not self clear");
    a_sleep_powerdown: assert property (st.cfg[CFG_SLEEP_BIT] |=> powerdown_o && !speed_indicator_out_o)
        else $error("sleep did not power down");
    a_wake_reinit: assert property ($fell(st.cfg[CFG_SLEEP_BIT]) |-> st.sm_start)
        else $error("wake without state machine reset");
    a_loopout_out: assert property (st.cfg[CFG_REMOTE_LOOPOUT_BIT] |=> remote_loopout_o)
        else $error("remote loopout not applied");
    a_result_fast_fdx: assert property ((an_complete_i && an_speed_100_i && an_full_duplex_i)
                                        |=> st.result == 4'h8)
        else $error("100 full duplex result wrong");
    a_result_slow_hdx: assert property ((an_complete_i && !an_speed_100_i && !an_full_duplex_i)
                                        |=> st.result == 4'h1)
        else $error("10 half duplex result wrong");
    a_result_hold: assert property (!an_complete_i |=> $stable(st.result))
        else $error("result changed without negotiation");
    a_idle_released: assert property (st.fsm == PVC_PRE |-> mdio_oe_n_o)
        else $error("data pin driven outside a read");

    c_read_frame: cover property (st.fsm == PVC_RD ##1 st.fsm == PVC_PRE);
    c_cfg_write: cover property (st.fsm == PVC_WR && mdc_rise && st.cnt == DATA_LAST && st.sel);
    c_sm_reset_done: cover property (gen_done);
    c_wake: cover property ($fell(st.cfg[CFG_SLEEP_BIT]));

endmodule

// *** design/pvc_sm_reset_gen.sv ***
module pvc_sm_reset_gen
    import pvc_pkg::*;
#(
    parameter int CYCLES = SM_RESET_CYCLES
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
        logic          done;
    } pvc_gen_t;

    pvc_gen_t st;
    pvc_gen_t next_st;

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (start_i) begin
            // a new request restarts the full pulse
            next_st.busy = 1'b1;
            next_st.cnt  = '0;
        end else if (st.busy) begin
            if (st.cnt == LAST) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt + CW'(1);
            end
        end
        if (rst_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st <= next_st;
    end

    assign busy_o = st.busy;
    assign done_o = st.done;

endmodule

// *** verif/pvc_mgmt_master.sv ***
module pvc_mgmt_master (
    input  wire logic sys_clk_i,
    input  wire logic dev_mdio_i,
    input  wire logic dev_oe_n_i,
    output logic      mdc_o,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic drv_en;
    logic drv_bit;

    initial begin
        mdc_o = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b0;
    end

    // pull-up when neither side drives the data line
    assign line_o = !dev_oe_n_i ? dev_mdio_i : (drv_en ? drv_bit : 1'b1);

    // one mdc period, two sys clocks low and two high; line sampled before the fall
    task automatic clk_bit(input logic en, input logic b, output logic seen);
        @(negedge sys_clk_i);
        seen = line_o;
        mdc_o = 1'b0;
        drv_en = en;
        drv_bit = b;
        repeat (2) @(negedge sys_clk_i);
        mdc_o = 1'b1;
        @(negedge sys_clk_i);
    endtask

    // whole management frame; read data sampled just before the 16 mdc falls after turnaround
    task automatic frame(input logic rd, input logic pre, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rdv);
        logic [31:0] word;
        logic        seen;
        word = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
        rdv = 16'h0000;
        if (pre) begin
            for (int i = 0; i < 32; i++) begin
                clk_bit(1'b1, 1'b1, seen);
            end
        end
        for (int j = 0; j < 32; j++) begin
            clk_bit(!(rd && j >= 14), word[31-j], seen);
            if (j >= 16) begin
                rdv[31-j] = seen;
            end
        end
        @(negedge sys_clk_i);
        drv_en = 1'b0;
    endtask
    // result bits are read after reset, after a status write and after each completed negotiation
endmodule

// *** verif/test_phy_vendor_config_status_regs.sv ***
module test_phy_vendor_config_status_regs
    import pvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int SMC = 4;
    localparam logic [4:0] MY_PA = 5'h03;

    logic sys_clk, rst, strap, raw, sd, spd, fdx, col, energy, an_done, an_100, an_fdx;
    logic mdc, line, mdio_q, oe_n, rmii, lgood, spd_ind, dcol, rpd, pdn, smr, loop;
    logic pre_on;
    logic [15:0] v;
    int mismatches, samples_checked, cycles, sm_high;
    logic [14:0] rows [6] = '{{6'b010010, 9'h0e1}, {6'b001100, 9'h011}, {6'b100001, 9'h100},
                              {6'b011110, 9'h072}, {6'b011110, 9'h070}, {6'b000001, 9'h014}};

    pvc_phy_regs #(.SM_CYCLES(SMC)) dut_u (
        .sys_clk_i(sys_clk), .rst_i(rst), .rmii_strap_i(strap), .phy_addr_i(MY_PA), .mdc_i(mdc),
        .mdio_i(line), .link_100_raw_i(raw), .signal_detect_i(sd), .speed_100_i(spd),
        .full_duplex_i(fdx), .collision_i(col), .energy_detect_i(energy), .an_complete_i(an_done),
        .an_speed_100_i(an_100), .an_full_duplex_i(an_fdx), .mdio_o(mdio_q), .mdio_oe_n_o(oe_n),
        .rmii_enable_o(rmii), .link_100_good_o(lgood), .speed_indicator_out_o(spd_ind),
        .duplex_collision_indicator_out_o(dcol), .reduced_powerdown_o(rpd), .powerdown_o(pdn),
        .sm_reset_o(smr), .remote_loopout_o(loop));

    pvc_mgmt_master mm (.sys_clk_i(sys_clk), .dev_mdio_i(mdio_q), .dev_oe_n_i(oe_n), .mdc_o(mdc),
                        .line_o(line));

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    // counted on the falling edge, half a period after the launching edge, so the registered pulse is settled
    always @(negedge sys_clk) begin
        cycles++;
        if (smr === 1'b1) begin
            sm_high++;
        end
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] unused;
        mm.frame(1'b0, pre_on, MY_PA, ra, d, unused);
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] exp, input string what);
        logic [15:0] got;
        mm.frame(1'b1, pre_on, MY_PA, ra, 16'h0000, got);
        check(what, got, exp);
    endtask

    task automatic check_outs(input logic [8:0] c);
        logic [6:0] e;
        logic       sl;
        sl = c[1];
        e = {c[8], c[7] | raw, !sl && (c[6] ? sd : spd), !sl && (c[5] ? (fdx | col) : fdx),
             c[4] && !energy && !sl, sl, c[0]};
        repeat (4) @(negedge sys_clk);
        check("outputs", {9'h000, rmii, lgood, spd_ind, dcol, rpd, pdn, loop}, {9'h000, e});
    endtask

    task automatic do_reset(input logic s);
        rst = 1'b1;
        strap = s;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
    endtask

    initial begin
        {raw, sd, spd, fdx, col, energy, an_done, an_100, an_fdx} = 9'h000;
        pre_on = 1'b1;
        do_reset(1'b1);
        rd(REG_CFG_ADDR, 16'h0110, "cfg after reset");
        rd(REG_STAT_ADDR, 16'hf000, "status after reset");
        for (int i = 0; i < 6; i++) begin
            {raw, sd, spd, fdx, col, energy} = rows[i][14:9];
            wr(REG_CFG_ADDR, {7'h00, rows[i][8:0]});
            check_outs(rows[i][8:0]);
            rd(REG_CFG_ADDR, {7'h00, rows[i][8:0]}, "cfg readback");
        end
        check("wake reset cycles", 16'(sm_high), 16'(SMC));
        pre_on = 1'b0;
        rd(REG_CFG_ADDR, 16'h0014, "cfg without preamble");
        wr(REG_CFG_ADDR, 16'h0018);
        pre_on = 1'b1;
        rd(REG_CFG_ADDR, 16'h0010, "state reset bit");
        check("state reset cycles", 16'(sm_high), 16'(2 * SMC));
        wr(REG_STAT_ADDR, 16'h0000);
        rd(REG_STAT_ADDR, 16'hf000, "status after write");
        rd(5'h05, 16'h0000, "unmapped read");
        mm.frame(1'b1, 1'b1, MY_PA ^ 5'h01, REG_CFG_ADDR, 16'h0000, v);
        check("foreign address read", v, 16'hffff);
        mm.frame(1'b0, 1'b1, MY_PA ^ 5'h01, REG_CFG_ADDR, 16'h00e1, v);
        rd(REG_CFG_ADDR, 16'h0010, "foreign address write");
        for (int k = 0; k < 4; k++) begin
            @(negedge sys_clk);
            {an_100, an_fdx} = 2'(k);
            an_done = 1'b1;
            @(negedge sys_clk);
            an_done = 1'b0;
            rd(REG_STAT_ADDR, 16'h1000 << k, "negotiation result");
        end
        do_reset(1'b0);
        rd(REG_CFG_ADDR, 16'h0010, "cfg after second reset");
        rd(REG_STAT_ADDR, 16'hf000, "status after second reset");
        check("rmii after second reset", {15'h0000, rmii}, 16'h0000);
        end_sim();
    end
endmodule
